/* File: core/prw_watchdog.sv */
// Purpose: Runaway watchdog with protected mode register and NMI ordering
// Assumes: CPU write, read and NMI handshake strobes are on clk
// Notes:   Only the NMI pin crosses in from outside
`timescale 1ns/1ps
`include "prw_consts.svh"
module prw_watchdog #(
  parameter int CNT_W = `PRW_CNT_W,
  parameter int EXP0  = `PRW_DIV_EXP0,
  parameter int EXP1  = `PRW_DIV_EXP1,
  parameter int EXP2  = `PRW_DIV_EXP2,
  parameter int EXP3  = `PRW_DIV_EXP3
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Protected write
  input  wire logic        prot_wr,
  input  wire logic [7:0]  prot_data,
  input  wire logic [7:0]  prot_check,
  // Ordinary write
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_addr,
  input  wire logic [7:0]  wr_data,
  // Read
  input  wire logic        rd_en,
  input  wire logic [15:0] rd_addr,
  output logic      [7:0]  rd_data_r,
  // Non-maskable interrupt handshake
  input  wire logic        nmi_pin,
  input  wire logic        nmi_ack,
  input  wire logic        nmi_done,
  output logic             nmi_req_r,
  output logic             nmi_src_wdt_r,
  // Event pulses and run level
  output logic             watchdog_overflow_irq_r,
  output logic             operand_error_irq_r,
  output logic             running_r
);

  logic [7:0]         watchdog_mode_register_r;
  logic               prot_ok;
  logic               nmi_pin_s1_r;
  logic               nmi_pin_s2_r;
  logic               nmi_pin_s3_r;
  logic               pin_edge;
  logic               pin_pend_r;
  logic               wdt_pend_r;
  logic               pin_ok;
  logic               wdt_ok;
  logic               take;
  logic               nmi_precedence_select;
  prw_pkg::prw_nmi_e  nmi_st_r;
  prw_pkg::prw_nmi_e  nmi_st_nxt;

  prw_cnt_if cnt_if ();

  // ----------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------
  assign prot_ok = prot_wr && (prot_check == ~prot_data);
  assign nmi_precedence_select = watchdog_mode_register_r[`PRW_BIT_PREC];

  // Ordinary writes have no path here at all; wr_en, wr_addr and wr_data
  // are accepted on the port only so the bus stays uniform.
  always_ff @(posedge clk)
  begin
    if (rst)
      watchdog_mode_register_r <= `PRW_MODE_RESET;
    else if (prot_ok && !watchdog_mode_register_r[`PRW_BIT_RUN])
      watchdog_mode_register_r <= prot_data & `PRW_MODE_MASK;
  end

  // Run only ever rises; software cannot lower it
  always_ff @(posedge clk)
  begin
    if (rst)
      running_r <= 1'b0;
    else if (prot_ok && prot_data[`PRW_BIT_RUN])
      running_r <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      operand_error_irq_r <= 1'b0;
    else
      operand_error_irq_r <= prot_wr && !prot_ok;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      rd_data_r <= 8'h00;
    else if (rd_en && rd_addr == `PRW_MODE_ADDR)
      rd_data_r <= watchdog_mode_register_r;
    else if (rd_en)
      rd_data_r <= 8'h00;
  end

  // ----------------------------------------------------------------
  // Counter hookup
  // ----------------------------------------------------------------
  assign cnt_if.clear = prot_ok && prot_data[`PRW_BIT_RUN];
  assign cnt_if.run   = watchdog_mode_register_r[`PRW_BIT_RUN];
  assign cnt_if.sel   = {watchdog_mode_register_r[`PRW_BIT_SEL_HI],
                         watchdog_mode_register_r[`PRW_BIT_SEL_LO]};

  prw_wdt_counter #(
    .CNT_W (CNT_W),
    .EXP0  (EXP0),
    .EXP1  (EXP1),
    .EXP2  (EXP2),
    .EXP3  (EXP3)
  ) u_counter (
    .clk (clk),
    .rst (rst),
    .ifc (cnt_if.cnt)
  );

  always_ff @(posedge clk)
  begin
    if (rst)
      watchdog_overflow_irq_r <= 1'b0;
    else
      watchdog_overflow_irq_r <= cnt_if.ovf;
  end

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      nmi_pin_s1_r <= 1'b0;
      nmi_pin_s2_r <= 1'b0;
      nmi_pin_s3_r <= 1'b0;
    end
    else
    begin
      nmi_pin_s1_r <= nmi_pin;
      nmi_pin_s2_r <= nmi_pin_s1_r;
      nmi_pin_s3_r <= nmi_pin_s2_r;
    end
  end

  assign pin_edge = nmi_pin_s2_r && !nmi_pin_s3_r;
  assign take     = nmi_ack && nmi_req_r;

  // ----------------------------------------------------------------
  // Pending flags; a new event beats an acceptance in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
      pin_pend_r <= 1'b0;
    else
      pin_pend_r <= pin_edge || (pin_pend_r && !(take && !nmi_src_wdt_r));
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      wdt_pend_r <= 1'b0;
    else
      wdt_pend_r <= cnt_if.ovf || (wdt_pend_r && !(take && nmi_src_wdt_r));
  end

  // ----------------------------------------------------------------
  // Request ordering
  // ----------------------------------------------------------------
  // The lower-ranked source may not interrupt the higher-ranked source's handler
  always_comb
  begin
    pin_ok = pin_pend_r && !(nmi_st_r == prw_pkg::PRW_NMI_WDT && nmi_precedence_select);
    wdt_ok = wdt_pend_r &&
             !(nmi_st_r == prw_pkg::PRW_NMI_PIN && !nmi_precedence_select);
  end

  always_ff @(posedge clk)
  begin
    if (rst || take)
    begin
      nmi_req_r     <= 1'b0;
      nmi_src_wdt_r <= 1'b0;
    end
    else
    begin
      nmi_req_r     <= pin_ok || wdt_ok;
      nmi_src_wdt_r <= wdt_ok && (!pin_ok || nmi_precedence_select);
    end
  end

  always_comb
  begin
    nmi_st_nxt = nmi_st_r;
    case (nmi_st_r)
      prw_pkg::PRW_NMI_IDLE,
      prw_pkg::PRW_NMI_PIN,
      prw_pkg::PRW_NMI_WDT:
      begin
        if (take)
          nmi_st_nxt = nmi_src_wdt_r ? prw_pkg::PRW_NMI_WDT : prw_pkg::PRW_NMI_PIN;
        else if (nmi_done)
          nmi_st_nxt = prw_pkg::PRW_NMI_IDLE;
      end
      default:
        nmi_st_nxt = prw_pkg::PRW_NMI_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      nmi_st_r <= prw_pkg::PRW_NMI_IDLE;
    else
      nmi_st_r <= nmi_st_nxt;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_plain_write_ignored;
    (wr_en && !prot_wr) |=> $stable(watchdog_mode_register_r) && !operand_error_irq_r;
  endproperty
  a_plain_write_ignored: assert property (p_plain_write_ignored) else $error("Plain write took");

  property p_bad_check;
    (prot_wr && prot_check != ~prot_data)
      |=> operand_error_irq_r && $stable(watchdog_mode_register_r);
  endproperty
  a_bad_check: assert property (p_bad_check) else $error("Bad check not refused");

  property p_good_write;
    (prot_ok && !watchdog_mode_register_r[`PRW_BIT_RUN])
      |=> watchdog_mode_register_r == ($past(prot_data) & `PRW_MODE_MASK);
  endproperty
  a_good_write: assert property (p_good_write) else $error("Protected write lost");

  property p_frozen;
    watchdog_mode_register_r[`PRW_BIT_RUN] |=> $stable(watchdog_mode_register_r);
  endproperty
  a_frozen: assert property (p_frozen) else $error("Mode changed while running");

  property p_never_stops;
    running_r |=> running_r && watchdog_mode_register_r[`PRW_BIT_RUN];
  endproperty
  a_never_stops: assert property (p_never_stops) else $error("Watchdog stopped");

  property p_read_back;
    (rd_en && rd_addr == `PRW_MODE_ADDR) |=> rd_data_r == $past(watchdog_mode_register_r);
  endproperty
  a_read_back: assert property (p_read_back) else $error("Read value wrong");

  // A pin request taken meanwhile may legally hold the watchdog back
  property p_ovf_to_req;
    (cnt_if.ovf && nmi_st_r == prw_pkg::PRW_NMI_IDLE && !take && !nmi_done)
      |=> wdt_pend_r ##1
          (nmi_req_r || (nmi_st_r == prw_pkg::PRW_NMI_PIN && !nmi_precedence_select));
  endproperty
  a_ovf_to_req: assert property (p_ovf_to_req) else $error("Overflow not requested");

  property p_order;
    (pin_pend_r && wdt_pend_r && nmi_st_r == prw_pkg::PRW_NMI_IDLE && !take)
      |=> nmi_req_r && (nmi_src_wdt_r == $past(nmi_precedence_select));
  endproperty
  a_order: assert property (p_order) else $error("Wrong NMI precedence");

  property p_hold_in_pin;
    (nmi_st_r == prw_pkg::PRW_NMI_PIN && !nmi_precedence_select && !take)
      |=> !(nmi_req_r && nmi_src_wdt_r);
  endproperty
  a_hold_in_pin: assert property (p_hold_in_pin) else $error("Watchdog broke pin service");

endmodule

/* File: core/prw_consts.svh */
// Purpose: Shared offsets, field positions, reset values and divider exponents
// Assumes: Included by bare name from every design file that needs it
// Notes:   Definitions only
`ifndef PRW_CONSTS_SVH
`define PRW_CONSTS_SVH

// ----------------------------------------------------------------
// Mode register map
// ----------------------------------------------------------------
`define PRW_MODE_ADDR     16'hffc2
`define PRW_MODE_RESET    8'h00
`define PRW_MODE_MASK     8'h96
`define PRW_BIT_RUN       7
`define PRW_BIT_PREC      4
`define PRW_BIT_SEL_HI    2
`define PRW_BIT_SEL_LO    1

// ----------------------------------------------------------------
// Overflow periods as powers of two of the clock
// ----------------------------------------------------------------
`define PRW_DIV_EXP0      17
`define PRW_DIV_EXP1      19
`define PRW_DIV_EXP2      20
`define PRW_DIV_EXP3      21
`define PRW_CNT_W         22

`endif

/* File: core/prw_pkg.sv */
// Purpose: Types shared by the watchdog modules
// Assumes: Nothing
// Notes:   Constants live in prw_consts.svh
package prw_pkg;

  // ----------------------------------------------------------------
  // Non-maskable service tracking
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    PRW_NMI_IDLE = 3'b001,
    PRW_NMI_PIN  = 3'b010,
    PRW_NMI_WDT  = 3'b100
  } prw_nmi_e;

  typedef logic [1:0] prw_sel_t;

endpackage

/* File: core/prw_cnt_if.sv */
// Purpose: Carrier between mode logic and overflow counter
// Assumes: Single clock domain
// Notes:   No clocking block
`timescale 1ns/1ps
interface prw_cnt_if;
  logic              clear;
  logic              run;
  prw_pkg::prw_sel_t sel;
  logic              ovf;

  modport ctl (output clear, output run, output sel, input ovf);
  modport cnt (input clear, input run, input sel, output ovf);
endinterface

/* File: core/prw_wdt_counter.sv */
// Purpose: Overflow counter with selectable power-of-two period
// Assumes: Clear and run come from the mode logic on the same clock
// Notes:   Wraps to zero after each overflow and keeps counting
`timescale 1ns/1ps
`include "prw_consts.svh"
module prw_wdt_counter #(
  parameter int CNT_W = `PRW_CNT_W,
  parameter int EXP0  = `PRW_DIV_EXP0,
  parameter int EXP1  = `PRW_DIV_EXP1,
  parameter int EXP2  = `PRW_DIV_EXP2,
  parameter int EXP3  = `PRW_DIV_EXP3
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control side
  prw_cnt_if.cnt    ifc
);

  logic [CNT_W-1:0] count_r;
  logic             ovf_r;
  logic [CNT_W-1:0] limit;

  // ----------------------------------------------------------------
  // Period decode
  // ----------------------------------------------------------------
  function automatic logic [CNT_W-1:0] last_count(input prw_pkg::prw_sel_t sel);
    logic [CNT_W:0] one;
    one = (CNT_W+1)'(1);
    case (sel)
      2'h0:    last_count = CNT_W'((one << EXP0) - one);
      2'h1:    last_count = CNT_W'((one << EXP1) - one);
      2'h2:    last_count = CNT_W'((one << EXP2) - one);
      default: last_count = CNT_W'((one << EXP3) - one);
    endcase
  endfunction

  assign limit = last_count(ifc.sel);

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst || ifc.clear)
      count_r <= '0;
    else if (ifc.run)
    begin
      if (count_r == limit)
        count_r <= '0;
      else
        count_r <= count_r + CNT_W'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      ovf_r <= 1'b0;
    else
      ovf_r <= ifc.run && !ifc.clear && (count_r == limit);
  end

  assign ifc.ovf = ovf_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_clear_zero;
    @(posedge clk) disable iff (rst)
      ifc.clear |=> (count_r == '0) && !ovf_r;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("Counter not cleared");

  property p_ovf_pulse;
    @(posedge clk) disable iff (rst)
      ovf_r |=> !ovf_r;
  endproperty
  a_ovf_pulse: assert property (p_ovf_pulse) else $error("Overflow not one cycle");

  property p_ovf_at_limit;
    @(posedge clk) disable iff (rst)
      (ifc.run && !ifc.clear && count_r == limit) |=> ovf_r && (count_r == '0);
  endproperty
  a_ovf_at_limit: assert property (p_ovf_at_limit) else $error("Missed overflow");

  property p_stopped_quiet;
    @(posedge clk) disable iff (rst)
      !ifc.run |=> !ovf_r && $stable(count_r);
  endproperty
  a_stopped_quiet: assert property (p_stopped_quiet) else $error("Counting while stopped");

endmodule

/* File: tb/prw_cpu_model.sv */
// Purpose: CPU side of the non-maskable request handshake
// Assumes: One request serviced at a time, no nesting
// Notes:   Acks one cycle after a request is seen; service length from bench
`timescale 1ns/1ps
module prw_cpu_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Handshake
  input  wire logic       nmi_req_r,
  input  wire logic       nmi_src_wdt_r,
  input  wire logic [7:0] svc_len,
  output logic            nmi_ack,
  output logic            nmi_done,
  // Service record
  output logic            busy_r,
  output logic [7:0]      served_cnt_r,
  output logic [7:0]      served_srcs_r
);
  logic [7:0] left_r;

  always_ff @(posedge clk)
  begin
    nmi_done <= 1'b0;
    if (rst)
    begin
      nmi_ack       <= 1'b0;
      busy_r        <= 1'b0;
      left_r        <= 8'h00;
      served_cnt_r  <= 8'h00;
      served_srcs_r <= 8'h00;
    end
    else if (nmi_ack)
    begin
      // Source is still held at the ack edge
      nmi_ack       <= 1'b0;
      busy_r        <= 1'b1;
      left_r        <= svc_len;
      served_cnt_r  <= served_cnt_r + 8'h01;
      served_srcs_r <= {served_srcs_r[6:0], nmi_src_wdt_r};
    end
    else if (busy_r)
    begin
      left_r <= left_r - 8'h01;
      if (left_r == 8'h00)
      begin
        busy_r   <= 1'b0;
        nmi_done <= 1'b1;
      end
    end
    else if (nmi_req_r)
      nmi_ack <= 1'b1;
  end
endmodule

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the runaway watchdog
// Assumes: Periods shortened to 2^3, 2^4, 2^5, 2^6 clocks
// Notes:   Inputs change by non-blocking assignment at rising edges
`timescale 1ns/1ps
module testbench;
  localparam int EXPS [4] = '{3, 4, 5, 6};

  logic        clk;
  logic        rst;
  logic        prot_wr;
  logic [7:0]  prot_data;
  logic [7:0]  prot_check;
  logic        wr_en;
  logic [15:0] wr_addr;
  logic [7:0]  wr_data;
  logic        rd_en;
  logic [15:0] rd_addr;
  logic [7:0]  rd_data_r;
  logic        nmi_pin;
  logic        nmi_ack;
  logic        nmi_done;
  logic        nmi_req_r;
  logic        nmi_src_wdt_r;
  logic        watchdog_overflow_irq_r;
  logic        operand_error_irq_r;
  logic        running_r;
  logic [7:0]  svc_len;
  logic        busy_r;
  logic [7:0]  served_cnt_r;
  logic [7:0]  served_srcs_r;
  int          error_cnt;
  int          tests_run;

  prw_watchdog #(.EXP0(3), .EXP1(4), .EXP2(5), .EXP3(6)) u_prw_watchdog (
    .clk(clk), .rst(rst), .prot_wr(prot_wr), .prot_data(prot_data),
    .prot_check(prot_check), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data_r(rd_data_r), .nmi_pin(nmi_pin),
    .nmi_ack(nmi_ack), .nmi_done(nmi_done), .nmi_req_r(nmi_req_r),
    .nmi_src_wdt_r(nmi_src_wdt_r), .watchdog_overflow_irq_r(watchdog_overflow_irq_r),
    .operand_error_irq_r(operand_error_irq_r), .running_r(running_r));

  prw_cpu_model u_prw_cpu_model (
    .clk(clk), .rst(rst), .nmi_req_r(nmi_req_r), .nmi_src_wdt_r(nmi_src_wdt_r),
    .svc_len(svc_len), .nmi_ack(nmi_ack), .nmi_done(nmi_done), .busy_r(busy_r),
    .served_cnt_r(served_cnt_r), .served_srcs_r(served_srcs_r));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (error_cnt == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({4'h0, running_r, nmi_req_r, watchdog_overflow_irq_r, operand_error_irq_r}, 8'h00);
  endtask

  task automatic prot(input logic [7:0] d, input logic [7:0] c, output logic err);
    @(posedge clk);
    prot_wr    <= 1'b1;
    prot_data  <= d;
    prot_check <= c;
    @(posedge clk);
    prot_wr <= 1'b0;
    #1;
    err = operand_error_irq_r;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd_en   <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rd_data_r, exp);
  endtask

  // Cycles from the last edge to the next overflow pulse
  task automatic wait_irq(output int k);
    for (k = 1; k < 300; k++)
    begin
      @(posedge clk);
      #1;
      if (watchdog_overflow_irq_r === 1'b1)
        return;
    end
  endtask

  task automatic wait_served(input logic [7:0] want);
    for (int n = 0; n < 300 && served_cnt_r !== want; n++)
    begin
      @(posedge clk);
      #1;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic s_access();
    logic e;
    do_reset();
    rd_chk(16'hffc2, 8'h00);
    rd_chk(16'hffc0, 8'h00);
    @(posedge clk);
    wr_en   <= 1'b1;
    wr_addr <= 16'hffc2;
    wr_data <= 8'h96;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
    chk({6'h0, operand_error_irq_r, running_r}, 8'h00);
    rd_chk(16'hffc2, 8'h00);
    prot(8'h86, 8'h00, e);
    chk({7'h0, e}, 8'h01);
    rd_chk(16'hffc2, 8'h00);
    prot(8'h7f, 8'h80, e);
    chk({6'h0, e, running_r}, 8'h00);
    rd_chk(16'hffc2, 8'h16);
  endtask

  task automatic s_periods();
    logic       e;
    logic [7:0] d;
    int         k;
    for (int i = 0; i < 4; i++)
    begin
      do_reset();
      d = 8'h80 | (8'(i) << 1);
      prot(d, ~d, e);
      wait_irq(k);
      chk(8'(k), 8'(2 ** EXPS[i] + 1));
      wait_irq(k);
      chk(8'(k), 8'(2 ** EXPS[i]));
    end
  endtask

  task automatic s_freeze();
    logic e;
    int   k;
    do_reset();
    prot(8'h82, 8'h7d, e);
    prot(8'h04, 8'hfb, e);
    prot(8'h00, 8'hff, e);
    // Same start value again, as software must repeat it
    prot(8'h82, 8'h7d, e);
    wait_irq(k);
    chk(8'(k), 8'h11);
    rd_chk(16'hffc2, 8'h82);
    chk({7'h0, running_r}, 8'h01);
  endtask

  task automatic s_pin_first();
    logic e;
    int   reqs;
    int   ovfs;
    do_reset();
    prot(8'h86, 8'h79, e);
    repeat (10) @(posedge clk);
    nmi_pin <= 1'b1;
    repeat (5) @(posedge clk);
    nmi_pin <= 1'b0;
    wait_served(8'h01);
    chk({7'h0, served_srcs_r[0]}, 8'h00);
    reqs = 0;
    ovfs = 0;
    for (int n = 0; n < 200 && busy_r === 1'b1; n++)
    begin
      @(posedge clk);
      #1;
      reqs += (nmi_req_r !== 1'b0);
      ovfs += (watchdog_overflow_irq_r === 1'b1);
    end
    chk({reqs[3:0], ovfs[3:0]}, 8'h01);
    wait_served(8'h02);
    chk({6'h0, served_srcs_r[1:0]}, 8'h01);
  endtask

  task automatic s_wdt_first();
    logic e;
    do_reset();
    prot(8'h96, 8'h69, e);
    wait_served(8'h01);
    repeat (10) @(posedge clk);
    nmi_pin <= 1'b1;
    repeat (5) @(posedge clk);
    nmi_pin <= 1'b0;
    wait_served(8'h02);
    chk({6'h0, served_srcs_r[1:0]}, 8'h03);
  endtask

  // ----------------------------------------------------------------
  // Clock, run and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    #20000;
    error_cnt++;
    end_of_test();
  end

  initial
  begin
    error_cnt  = 0;
    tests_run  = 0;
    rst        = 1'b1;
    prot_wr    = 1'b0;
    prot_data  = 8'h00;
    prot_check = 8'h00;
    wr_en      = 1'b0;
    wr_addr    = 16'h0000;
    wr_data    = 8'h00;
    rd_en      = 1'b0;
    rd_addr    = 16'h0000;
    nmi_pin    = 1'b0;
    svc_len    = 8'h64;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    s_access();
    s_periods();
    s_freeze();
    s_pin_first();
    s_wdt_first();
    end_of_test();
  end
endmodule
